/* rtl/ddcfe_pkg.sv */
`default_nettype none
package ddcfe_pkg;
	// ========================================
	// register map, byte addresses
	localparam logic [7:0] OFS_CONFIG = 8'h00;
	localparam logic [7:0] OFS_AGC_GAIN = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_SAMPLE = 8'h0C;
	localparam logic [7:0] OFS_NCO = 8'h10;
	// ========================================
	// field positions and reset values
	localparam int CFG_W = 8;
	localparam int AGC_HI_LSB = 16;
	localparam int STAT_GAIN_LSB = 0;
	localparam int STAT_CHOICE_BIT = 4;
	localparam int STAT_BUSY_BIT = 5;
	localparam logic [7:0] CONFIG_RESET = 8'h0D;
	localparam logic [31:0] AGC_GAIN_RESET = 32'h0000_0000;
	localparam logic [3:0] SHIFT_MAX = 4'hF;
	// ========================================
	// sample, serial word, byte and pin sizes; bus response codes
	localparam int SAMPLE_W = 14;
	localparam int OFFSET_W = 32;
	localparam int BYTE_W = 8;
	localparam int PIN_W = 23;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// ========================================
	// types
	typedef struct packed {
		logic [3:0] shift;
		logic [1:0] len_code;
		logic interp;
		logic twos;
	} ddcfe_cfg_s;
	typedef struct packed {
		logic valid;
		logic [SAMPLE_W-1:0] data;
	} ddcfe_sample_s;
	typedef enum logic [1:0] {
		SER_IDLE = 2'b01,
		SER_SHIFT = 2'b10
	} ddcfe_ser_e;
endpackage
`default_nettype wire

/* rtl/ddcfe_front_end.sv */
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`default_nettype none
// How it works
// [RULE_01] input steps happen on front-end clock rises
// [RULE_02] 14-bit sample, offset binary or two's complement
// [RULE_03] gated: one sample per enabled front-end cycle
// [RULE_04] add gain pins to shift, saturate at F
// [RULE_05] each gain pin step adds 6 dB
// [RULE_06] back-end work runs on back-end clock rises
// [RULE_07] domain transfer safe for unrelated clocks
// [RULE_08] loop gain choice high selects gain 1
// [RULE_09] serial offset loaded into carrier NCO
// [RULE_10] offset word 8, 16, 24 or 32 bits
// [RULE_11] sync comes one cycle before the MSB
// [RULE_12] MSB first; NCO updates after last bit
module ddcfe_front_end #(
	parameter int AGC_W = 8
)(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write channels
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read channels
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// device pins
	input wire logic front_end_clock,
	input wire logic back_end_clock,
	input wire logic [ddcfe_pkg::SAMPLE_W-1:0] sample_in,
	input wire logic sample_enable_n,
	input wire logic [2:0] gain_offset_pins,
	input wire logic loop_gain_choice,
	input wire logic carrier_offset_serial,
	input wire logic carrier_offset_sync,
	// front-end results
	output ddcfe_pkg::ddcfe_sample_s fe_sample,
	output logic [3:0] shift_code_eff,
	output logic [ddcfe_pkg::OFFSET_W-1:0] carrier_nco_offset,
	output logic carrier_nco_load,
	// back-end results
	output ddcfe_pkg::ddcfe_sample_s be_sample,
	output logic [AGC_W-1:0] agc_loop_gain
);
	import ddcfe_pkg::*;

	if (AGC_W < 1 || AGC_W > 16)
		$error("AGC_W must lie between 1 and 16");

	// ========================================
	// pin synchronisers
	logic [PIN_W-1:0] pins_raw;
	logic [PIN_W-1:0] sync1_q;
	logic [PIN_W-1:0] sync2_q;
	logic fe_prev_q;
	logic be_prev_q;
	logic fe_rise;
	logic be_rise;
	logic [SAMPLE_W-1:0] pin_data;
	logic pin_en_n;
	logic [2:0] pin_gain;
	logic pin_choice;
	logic pin_ser;
	logic pin_sync;

	assign pins_raw = {front_end_clock, back_end_clock, sample_in, sample_enable_n,
		gain_offset_pins, loop_gain_choice, carrier_offset_serial, carrier_offset_sync};
	assign {pin_data, pin_en_n, pin_gain, pin_choice, pin_ser, pin_sync} = sync2_q[20:0];

	// two stages for every pin; only the second stage is read
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sync1_q <= '0;
			sync2_q <= '0;
			fe_prev_q <= 1'b0;
			be_prev_q <= 1'b0;
		end
		else
		begin
			sync1_q <= pins_raw;
			sync2_q <= sync1_q;
			fe_prev_q <= sync2_q[22];
			be_prev_q <= sync2_q[21];
		end
	end

	// clock pins become one-cycle enables; data pins share the same delay
	assign fe_rise = sync2_q[22] & ~fe_prev_q; // RULE_01
	assign be_rise = sync2_q[21] & ~be_prev_q; // RULE_06

	// ========================================
	// register file state
	ddcfe_cfg_s cfg_q;
	ddcfe_cfg_s cfg_d;
	logic [31:0] agc_q;
	logic [31:0] agc_d;
	logic aw_full_q;
	logic aw_full_d;
	logic [7:0] awaddr_q;
	logic [7:0] awaddr_d;
	logic w_full_q;
	logic w_full_d;
	logic [31:0] wdata_q;
	logic [31:0] wdata_d;
	logic [3:0] wstrb_q;
	logic [3:0] wstrb_d;
	logic bvalid_q;
	logic bvalid_d;
	logic [1:0] bresp_q;
	logic [1:0] bresp_d;
	logic rvalid_q;
	logic rvalid_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [1:0] rresp_q;
	logic [1:0] rresp_d;
	logic [31:0] status_w;
	logic ser_busy;

	assign s_axi_awready = ~aw_full_q & ~bvalid_q;
	assign s_axi_wready = ~w_full_q & ~bvalid_q;
	assign s_axi_arready = ~rvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	always_comb
	begin
		status_w = '0;
		status_w[STAT_GAIN_LSB +: 4] = shift_code_eff;
		status_w[STAT_CHOICE_BIT] = pin_choice;
		status_w[STAT_BUSY_BIT] = ser_busy;
	end

	// address and data are held apart so either may arrive first
	always_comb
	begin
		cfg_d = cfg_q;
		agc_d = agc_q;
		aw_full_d = aw_full_q;
		awaddr_d = awaddr_q;
		w_full_d = w_full_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (s_axi_awvalid && s_axi_awready)
		begin
			aw_full_d = 1'b1;
			awaddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			w_full_d = 1'b1;
			wdata_d = s_axi_wdata;
			wstrb_d = s_axi_wstrb;
		end
		if (aw_full_q && w_full_q && !bvalid_q)
		begin
			aw_full_d = 1'b0;
			w_full_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = RESP_OKAY;
			if ({awaddr_q[7:2], 2'b00} == OFS_CONFIG)
			begin
				if (wstrb_q[0])
					cfg_d = ddcfe_cfg_s'(wdata_q[CFG_W-1:0]);
			end
			else if ({awaddr_q[7:2], 2'b00} == OFS_AGC_GAIN)
			begin
				for (int b = 0; b < 4; b++)
					if (wstrb_q[b])
						agc_d[b*BYTE_W +: BYTE_W] = wdata_q[b*BYTE_W +: BYTE_W];
			end
			else if ({awaddr_q[7:2], 2'b00} != OFS_STATUS
				&& {awaddr_q[7:2], 2'b00} != OFS_SAMPLE
				&& {awaddr_q[7:2], 2'b00} != OFS_NCO)
				bresp_d = RESP_SLVERR; // unmapped
		end
		if (bvalid_q && s_axi_bready)
			bvalid_d = 1'b0;
		if (rvalid_q && s_axi_rready)
			rvalid_d = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_d = 1'b1;
			rresp_d = RESP_OKAY;
			unique case ({s_axi_araddr[7:2], 2'b00})
				OFS_CONFIG: rdata_d = {24'h00_0000, cfg_q};
				OFS_AGC_GAIN: rdata_d = agc_q;
				OFS_STATUS: rdata_d = status_w;
				OFS_SAMPLE: rdata_d = {18'h0_0000, be_sample.data};
				OFS_NCO: rdata_d = carrier_nco_offset;
				default:
				begin
					rdata_d = 32'h0000_0000;
					rresp_d = RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cfg_q <= ddcfe_cfg_s'(CONFIG_RESET);
			agc_q <= AGC_GAIN_RESET;
			aw_full_q <= 1'b0;
			awaddr_q <= 8'h00;
			w_full_q <= 1'b0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= RESP_OKAY;
		end
		else
		begin
			cfg_q <= cfg_d;
			agc_q <= agc_d;
			aw_full_q <= aw_full_d;
			awaddr_q <= awaddr_d;
			w_full_q <= w_full_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end

	// ========================================
	// sample intake and gain offset
	ddcfe_sample_s fe_q;
	ddcfe_sample_s fe_d;
	logic [3:0] shift_q;
	logic [3:0] shift_d;
	logic [4:0] shift_sum;
	logic [SAMPLE_W-1:0] conv;

	// offset binary becomes two's complement by flipping the top bit
	assign conv = cfg_q.twos ? pin_data : {~pin_data[SAMPLE_W-1], pin_data[SAMPLE_W-2:0]}; // RULE_02
	// each shift code step is a 6 dB gain step in the shifter
	assign shift_sum = {1'b0, cfg_q.shift} + {2'b00, pin_gain}; // RULE_05

	always_comb
	begin
		fe_d = fe_q;
		fe_d.valid = 1'b0;
		shift_d = shift_q;
		if (fe_rise) // RULE_01
		begin
			shift_d = shift_sum[4] ? SHIFT_MAX : shift_sum[3:0]; // RULE_04
			if (!pin_en_n) // RULE_03
			begin
				fe_d.valid = 1'b1;
				fe_d.data = conv;
			end
			else if (cfg_q.interp)
			begin
				// interpolated: disabled cycles carry a zero sample
				fe_d.valid = 1'b1;
				fe_d.data = '0;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			fe_q <= '0;
			shift_q <= 4'h0;
		end
		else
		begin
			fe_q <= fe_d;
			shift_q <= shift_d;
		end
	end

	assign fe_sample = fe_q;
	assign shift_code_eff = shift_q;

	// ========================================
	// serial carrier offset
	ddcfe_ser_e ser_q;
	ddcfe_ser_e ser_d;
	logic [4:0] cnt_q;
	logic [4:0] cnt_d;
	logic [1:0] len_q;
	logic [1:0] len_d;
	logic [OFFSET_W-1:0] sh_q;
	logic [OFFSET_W-1:0] sh_d;
	logic [OFFSET_W-1:0] nco_q;
	logic [OFFSET_W-1:0] nco_d;
	logic load_q;
	logic load_d;
	logic [4:0] last_bit;

	assign ser_busy = (ser_q == SER_SHIFT);
	assign last_bit = {len_q, 3'b111}; // RULE_10

	// short words are left-justified so they keep their frequency weight
	always_comb
	begin
		ser_d = ser_q;
		cnt_d = cnt_q;
		len_d = len_q;
		sh_d = sh_q;
		nco_d = nco_q;
		load_d = 1'b0;
		if (fe_rise) // RULE_09
		begin
			unique case (ser_q)
				SER_IDLE:
				begin
					if (pin_sync) // RULE_11
					begin
						ser_d = SER_SHIFT;
						cnt_d = 5'd0;
						len_d = cfg_q.len_code;
					end
				end
				SER_SHIFT:
				begin
					sh_d = {sh_q[OFFSET_W-2:0], pin_ser}; // RULE_12
					cnt_d = cnt_q + 5'd1;
					if (cnt_q == last_bit) // RULE_12
					begin
						ser_d = SER_IDLE;
						load_d = 1'b1;
						unique case (len_q)
							2'd0: nco_d = {sh_d[7:0], 24'h00_0000};
							2'd1: nco_d = {sh_d[15:0], 16'h0000};
							2'd2: nco_d = {sh_d[23:0], 8'h00};
							2'd3: nco_d = sh_d;
						endcase
					end
					// a fresh sync restarts the word
					if (pin_sync)
					begin
						ser_d = SER_SHIFT;
						cnt_d = 5'd0;
						len_d = cfg_q.len_code;
					end
				end
				default: ser_d = SER_IDLE;
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ser_q <= SER_IDLE;
			cnt_q <= 5'd0;
			len_q <= 2'd0;
			sh_q <= '0;
			nco_q <= '0;
			load_q <= 1'b0;
		end
		else
		begin
			ser_q <= ser_d;
			cnt_q <= cnt_d;
			len_q <= len_d;
			sh_q <= sh_d;
			nco_q <= nco_d;
			load_q <= load_d;
		end
	end

	assign carrier_nco_offset = nco_q;
	assign carrier_nco_load = load_q;

	// ========================================
	// back-end handoff and loop gain choice
	// a toggle flags each new sample; the back end takes it on its own rise
	logic tog_fe_q;
	logic tog_be_q;
	logic [SAMPLE_W-1:0] hold_q;
	ddcfe_sample_s be_q;
	logic [AGC_W-1:0] gain_q;
	logic tog_fe_d;
	logic tog_be_d;
	logic [SAMPLE_W-1:0] hold_d;
	ddcfe_sample_s be_d;
	logic [AGC_W-1:0] gain_d;

	always_comb
	begin
		tog_fe_d = tog_fe_q;
		hold_d = hold_q;
		tog_be_d = tog_be_q;
		be_d = be_q;
		be_d.valid = 1'b0;
		gain_d = gain_q;
		if (fe_q.valid)
		begin
			hold_d = fe_q.data;
			tog_fe_d = ~tog_fe_q; // RULE_07
		end
		if (be_rise) // RULE_06
		begin
			gain_d = pin_choice ? agc_q[AGC_HI_LSB +: AGC_W] : agc_q[AGC_W-1:0]; // RULE_08
			if (tog_be_q != tog_fe_q) // RULE_07
			begin
				tog_be_d = tog_fe_q;
				be_d.valid = 1'b1;
				be_d.data = hold_q;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			tog_fe_q <= 1'b0;
			tog_be_q <= 1'b0;
			hold_q <= '0;
			be_q <= '0;
			gain_q <= '0;
		end
		else
		begin
			tog_fe_q <= tog_fe_d;
			tog_be_q <= tog_be_d;
			hold_q <= hold_d;
			be_q <= be_d;
			gain_q <= gain_d;
		end
	end

	assign be_sample = be_q;
	assign agc_loop_gain = gain_q;
endmodule
`default_nettype wire

/* testbench/ddcfe_front_end_asserts.sv */
`default_nettype none
module ddcfe_checker
	import ddcfe_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// pins
	input wire logic front_end_clock,
	input wire logic back_end_clock,
	input wire logic [2:0] gain_offset_pins,
	// results
	input wire ddcfe_pkg::ddcfe_sample_s fe_sample,
	input wire logic [3:0] shift_code_eff,
	input wire logic [ddcfe_pkg::OFFSET_W-1:0] carrier_nco_offset,
	input wire logic carrier_nco_load,
	input wire ddcfe_pkg::ddcfe_sample_s be_sample
);
	timeunit 1ns;
	timeprecision 1ps;
	// ====
	// last two samples; a fresh one may race the back-end copy
	logic [SAMPLE_W-1:0] last_q, last_d, prev_q, prev_d;
	always_comb
	begin
		last_d = fe_sample.valid ? fe_sample.data : last_q;
		prev_d = fe_sample.valid ? last_q : prev_q;
	end
	always_ff @(posedge aclk)
	begin
		last_q <= last_d;
		prev_q <= prev_d;
	end
	// ====
	// properties
	default clocking dc @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	AST_FE_RISE: assert property (fe_sample.valid |->
		$past(front_end_clock, 3) && !$past(front_end_clock, 6)) else $error("fe rise");
	AST_FE_ONCE: assert property (fe_sample.valid |=> !fe_sample.valid [*3])
		else $error("fe twice");
	AST_SHIFT: assert property (fe_sample.valid |->
		shift_code_eff >= {1'h0, $past(gain_offset_pins, 3)}) else $error("shift low");
	AST_LOAD_ONCE: assert property (carrier_nco_load |=> !carrier_nco_load [*8])
		else $error("load twice");
	AST_NCO_HOLD: assert property ($changed(carrier_nco_offset) |-> carrier_nco_load)
		else $error("nco moved");
	AST_LOAD_RISE: assert property (carrier_nco_load |->
		$past(front_end_clock, 3) && !$past(front_end_clock, 6)) else $error("load rise");
	AST_BE_RISE: assert property (be_sample.valid |->
		$past(back_end_clock, 3) && !$past(back_end_clock, 6)) else $error("be rise");
	AST_BE_DATA: assert property (be_sample.valid |->
		be_sample.data == last_q || be_sample.data == prev_q) else $error("be data");
endmodule
bind ddcfe_front_end ddcfe_checker ddcfe_checker_inst (.aclk(aclk), .aresetn(aresetn),
	.front_end_clock(front_end_clock), .back_end_clock(back_end_clock),
	.gain_offset_pins(gain_offset_pins), .fe_sample(fe_sample), .be_sample(be_sample),
	.shift_code_eff(shift_code_eff), .carrier_nco_offset(carrier_nco_offset),
	.carrier_nco_load(carrier_nco_load));
`default_nettype wire

/* testbench/ddcfe_partner.sv */
`default_nettype none
module ddcfe_partner
	import ddcfe_pkg::*;
(
	// clock
	input wire logic aclk,
	// converter and tracking loop pins
	output logic front_end_clock,
	output logic [ddcfe_pkg::SAMPLE_W-1:0] sample_in,
	output logic sample_enable_n,
	output logic carrier_offset_serial,
	output logic carrier_offset_sync
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] cnt_q = 3'h0;
	logic clk_q = 1'h0;
	logic en_n_q = 1'h1;
	logic ser_q = 1'h0;
	logic sync_q = 1'h0;
	logic [13:0] din_q = 14'h0;
	logic [13:0] sq[$];
	logic bq[$];
	logic yq[$];
	// ====
	// one driver per pin; registers start idle with the enable off
	assign front_end_clock = clk_q;
	assign sample_in = din_q;
	assign sample_enable_n = en_n_q;
	assign carrier_offset_serial = ser_q;
	assign carrier_offset_sync = sync_q;
	// clock of eight aclk; data moves on its fall, idle data and serial lines wander
	always @(posedge aclk)
	begin
		cnt_q <= cnt_q + 3'h1;
		clk_q <= cnt_q >= 3'h3 && cnt_q != 3'h7;
		if (cnt_q == 3'h7)
		begin
			en_n_q <= sq.size() == 0;
			din_q <= sq.size() ? sq.pop_front() : ~din_q;
			sync_q <= yq.size() ? yq.pop_front() : 1'h0;
			ser_q <= bq.size() ? bq.pop_front() : ~ser_q;
		end
	end
	task automatic put_sample(input logic [13:0] s);
		sq.push_back(s);
	endtask
	// left-justified word, top n bits sent msb first after sync
	task automatic put_word(input logic [31:0] w, input int n);
		yq.push_back(1'h1);
		bq.push_back(~w[31]);
		for (int i = 0; i < n; i++)
		begin
			yq.push_back(1'h0);
			bq.push_back(w[31-i]);
		end
	endtask
endmodule
`default_nettype wire

/* testbench/ddcfe_front_end_tb.sv */
`default_nettype none
module ddcfe_front_end_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ddcfe_pkg::*;
	// ====
	// bench signals
	logic aclk = 1'h0, aresetn = 1'h0, back_end_clock = 1'h0, loop_gain_choice = 1'h0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [2:0] gain_offset_pins = 3'h0;
	wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire logic [1:0] s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata, carrier_nco_offset;
	wire logic front_end_clock, sample_enable_n, carrier_offset_serial, carrier_offset_sync;
	wire logic carrier_nco_load;
	wire logic [13:0] sample_in;
	wire logic [3:0] shift_code_eff;
	wire logic [7:0] agc_loop_gain;
	wire ddcfe_sample_s fe_sample, be_sample;
	int miscompares = 0, tests_run = 0, fe_cnt = 0, ld_cnt = 0, bc = 0;
	ddcfe_front_end ddcfe_front_end_inst (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.front_end_clock(front_end_clock), .back_end_clock(back_end_clock),
		.sample_in(sample_in), .sample_enable_n(sample_enable_n),
		.gain_offset_pins(gain_offset_pins), .loop_gain_choice(loop_gain_choice),
		.carrier_offset_serial(carrier_offset_serial),
		.carrier_offset_sync(carrier_offset_sync),
		.fe_sample(fe_sample), .shift_code_eff(shift_code_eff),
		.carrier_nco_offset(carrier_nco_offset), .carrier_nco_load(carrier_nco_load),
		.be_sample(be_sample), .agc_loop_gain(agc_loop_gain)
	);
	ddcfe_partner ddcfe_partner_inst (
		.aclk(aclk), .front_end_clock(front_end_clock), .sample_in(sample_in),
		.sample_enable_n(sample_enable_n), .carrier_offset_serial(carrier_offset_serial),
		.carrier_offset_sync(carrier_offset_sync)
	);
	// clock, back-end pin at a tenth of aclk, event counts
	always #10 aclk = ~aclk;
	always @(posedge aclk)
	begin
		bc <= bc == 4 ? 0 : bc + 1;
		if (bc == 4) back_end_clock <= ~back_end_clock;
		if (fe_sample.valid) fe_cnt <= fe_cnt + 1;
		if (carrier_nco_load) ld_cnt <= ld_cnt + 1;
	end
	// ====
	// shared tasks
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
			miscompares++;
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		forever
		begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'h0;
		chk("bresp", r, s_axi_bresp);
	endtask
	task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		forever
		begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid) break;
		end
		s_axi_rready <= 1'h0;
		chk("rdata", d, s_axi_rdata);
		chk("rresp", r, s_axi_rresp);
	endtask
	// bounded wait: 0 front-end sample, 1 back-end sample, 2 offset load
	task automatic wt(input int k);
		repeat (400)
		begin
			@(posedge aclk);
			if ((k == 0 ? fe_sample.valid : k == 1 ? be_sample.valid : carrier_nco_load) === 1'h1)
				break;
		end
		chk("wait", 1, k == 0 ? fe_sample.valid : k == 1 ? be_sample.valid : carrier_nco_load);
	endtask
	// ====
	// scenarios
	task automatic t_regs;
		axr(OFS_CONFIG, {24'h0, CONFIG_RESET}, RESP_OKAY);
		axr(OFS_AGC_GAIN, AGC_GAIN_RESET, RESP_OKAY);
		axw(8'h1C, 32'hFFFF_FFFF, RESP_SLVERR);
		axr(8'h1C, 32'h0, RESP_SLVERR);
		$display("done regs");
	endtask
	// three back-to-back samples in each number format
	task automatic t_format;
		logic [13:0] s[3] = '{14'h0000, 14'h3FFF, 14'h2001};
		int n;
		for (int m = 0; m < 2; m++)
		begin
			axw(OFS_CONFIG, {28'h0, 3'h6, m[0]}, RESP_OKAY);
			n = fe_cnt;
			for (int i = 0; i < 3; i++) ddcfe_partner_inst.put_sample(s[i]);
			for (int i = 0; i < 3; i++)
			begin
				wt(0);
				chk("sample", m ? s[i] : s[i] ^ 14'h2000, fe_sample.data);
			end
			repeat (40) @(posedge aclk);
			chk("count", n + 3, fe_cnt);
		end
		// interpolated: idle rises still give a zero sample each, five per 40 cycles
		axw(OFS_CONFIG, 32'h0000_000F, RESP_OKAY);
		wt(0);
		chk("stuffed", 32'h0, fe_sample.data);
		n = fe_cnt;
		repeat (40) @(posedge aclk);
		chk("rate", n + 5, fe_cnt);
		$display("done format");
	endtask
	task automatic t_gain;
		axw(OFS_CONFIG, 32'hAD, RESP_OKAY);
		for (int p = 0; p < 8; p++)
		begin
			gain_offset_pins <= p[2:0];
			repeat (8) @(posedge aclk);
			ddcfe_partner_inst.put_sample(14'h0155);
			wt(0);
			chk("shift", p > 5 ? 15 : p + 10, shift_code_eff);
		end
		axr(OFS_STATUS, 32'h0000_000F, RESP_OKAY);
		$display("done gain");
	endtask
	// a cut-short word is restarted by the next sync
	task automatic t_serial;
		logic [31:0] w = 32'hA5C3_96E1;
		int n;
		for (int c = 0; c < 4; c++)
		begin
			axw(OFS_CONFIG, {28'h0, c[1:0], 2'h1}, RESP_OKAY);
			n = ld_cnt;
			ddcfe_partner_inst.put_word(~w, 5);
			ddcfe_partner_inst.put_word(w, 8 * (c + 1));
			wt(2);
			chk("offset", w & ~(32'hFFFF_FFFF >> (8 * (c + 1))), carrier_nco_offset);
			repeat (20) @(posedge aclk);
			chk("loads", n + 1, ld_cnt);
		end
		axr(OFS_NCO, w, RESP_OKAY);
		$display("done serial");
	endtask
	task automatic t_back;
		axw(OFS_CONFIG, 32'h0D, RESP_OKAY);
		axw(OFS_AGC_GAIN, 32'h00C3_005A, RESP_OKAY);
		ddcfe_partner_inst.put_sample(14'h1234);
		wt(1);
		chk("be", 14'h1234, be_sample.data);
		axr(OFS_SAMPLE, 32'h1234, RESP_OKAY);
		loop_gain_choice <= 1'h1;
		repeat (30) @(posedge aclk);
		chk("gain1", 8'hC3, agc_loop_gain);
		loop_gain_choice <= 1'h0;
		repeat (30) @(posedge aclk);
		chk("gain0", 8'h5A, agc_loop_gain);
		$display("done back");
	endtask
	task automatic final_report;
		$display("tests_run %0d miscompares %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// main sequence after a 16-cycle reset
	initial
	begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		t_regs;
		t_format;
		t_gain;
		t_serial;
		t_back;
		final_report;
	end
	// watchdog, well beyond the under two thousand cycles the tests need
	initial
	begin
		repeat (20000) @(posedge aclk);
		miscompares++;
		final_report;
	end
endmodule
`default_nettype wire
